// File: rtl/pwc_pkg.sv
/*
  Package for the power and wake controller: register offsets, field
  positions, power state codes and the carrier structs.
  Assumes a single 32-bit register port on the core clock.
*/
package pwc_pkg;
  // Operational register offsets
  localparam logic [7:0] CMD_OFS   = 8'h00;
  localparam logic [7:0] RXPTR_OFS = 8'h30;
  localparam logic [7:0] WAKE_OFS  = 8'h40;
  localparam logic [7:0] FILT_OFS  = 8'h48;
  localparam logic [7:0] PIC_OFS   = 8'hc4;
  localparam logic [7:0] PIM_OFS   = 8'hc8;
  // Configuration space offset
  localparam logic [7:0] PM_OFS    = 8'h44;
  // Field positions
  localparam int CMD_RXON_BIT  = 2;
  localparam int CMD_RXOFF_BIT = 3;
  localparam int PM_EN_BIT     = 8;
  localparam int PM_STS_BIT    = 15;
  localparam int WC_PHY_BIT    = 0;
  localparam int WC_MAGIC_BIT  = 9;
  localparam int WC_PHY_HIT    = 22;
  localparam int WC_MAGIC_HIT  = 25;
  localparam int WC_PIN_LVL    = 30;
  localparam int RF_ON_BIT     = 31;
  localparam int PIC_INT_BIT   = 1;
  // Reset value and wake source enable mask
  localparam logic [31:0] REG_RST  = 32'h0000_0000;
  localparam logic [31:0] WC_EN_MASK = 32'h0000_0201;
  // Wake frame shape
  localparam logic [7:0] SYNC_BYTE  = 8'hff;
  localparam logic [2:0] SYNC_LEN   = 3'h6;
  localparam logic [2:0] MAC_LAST   = 3'h5;
  localparam logic [3:0] COPY_LAST  = 4'hf;
  // Power state field codes
  typedef enum logic [1:0] {
    PS_D0 = 2'b00,
    PS_D1 = 2'b01,
    PS_D2 = 2'b10,
    PS_D3 = 2'b11
  } pwc_pstate_type;
  // Register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        cfg;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } pwc_req_type;
  // One received byte with its framing
  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic       good;
    logic       pass;
    logic [7:0] data;
  } pwc_beat_type;
endpackage

// File: rtl/pwc_wake_ctrl.sv
/*
  Power state and wake control: power management control/status, wake
  command/status, receive command bits, filter and PHY interrupt registers,
  wake frame detector, wake request pin and power gating outputs.
  Assumes register requests and receive bytes arrive on sys_clk_i; the PHY
  interrupt and the wake pin level come from outside and are synchronised.
*/
// Functional notes
// R1 - Bit 8 at 44h enables wake pin
// R2 - Bit 15 flags wake; pin follows flag
// R3 - Wake flag cleared only by writing one
// R4 - Sleep operation never signals wake
// R5 - Wake-enabled operation signals wake events
// R6 - Wake enable needs both filters passed
// R7 - D1: config only, no DMA, tx, interrupts; operational registers stay accessible
// R8 - D1/D2 keep receiving into FIFO
// R9 - Tolerate stopped clock in D2/D3
// R10 - D3 powers PHY only when wake configured
// R11 - Leaving D3hot resets config except wake bits
// R12 - Host disables receiver, zeroes descriptor pointer
// R13 - Null pointer with receiver on: silent receive
// R14 - Host sets filter enable for every wake
// R15 - Host programs PHY interrupt registers
// R16 - Wake sources: bit 9 frame, bit 0 PHY
// R17 - Filter control bit 31 enables filter
// R18 - One write sets enable, clears flag, D3
// R19 - Host writes enable with or before state
// R20 - Detect six FFh then sixteen address copies
// R21 - Wake event drives request pin low
// R22 - Clearing enable releases request pin
// R23 - State codes D0..D3hot are 00..11
// R24 - Flag only enabled sources; record source
`timescale 1ns/1ps
module pwc_wake_ctrl (
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_n_i,
  input  wire pwc_pkg::pwc_req_type reg_req_i,
  output logic [31:0]               reg_rdata_o,
  input  wire pwc_pkg::pwc_beat_type rx_beat_i,
  input  wire logic [47:0]          station_addr_i,
  input  wire logic                 rx_fifo_full_i,
  input  wire logic                 phy_irq_i,
  input  wire logic                 wake_req_pin_i,
  output logic                      wake_req_pin_o,
  output logic                      wake_req_oe_o,
  output logic                      frame_keep_o,
  output logic                      frame_store_o,
  output logic                      dma_allow_o,
  output logic                      tx_allow_o,
  output logic                      irq_allow_o,
  output logic                      silent_rx_o,
  output logic                      phy_power_on_o,
  output logic                      cfg_reset_o,
  output logic [1:0]                power_state_o
);
  typedef enum {MP_SYNC, MP_ADDR} pwc_mp_type;

  // Address hit decode, shared by write and read paths
  function automatic logic hit(input pwc_pkg::pwc_req_type r,
                               input logic cfg, input logic [7:0] ofs);
    hit = (r.cfg == cfg) && (r.addr == ofs);
  endfunction

  // Station address byte, first byte on the wire in the low bits
  function automatic logic [7:0] mac_byte(input logic [47:0] a,
                                          input logic [2:0] i);
    mac_byte = a[8*i +: 8];
  endfunction

  logic                      wake_en_ff;     // Wake signalling enable
  logic                      wake_sts_ff;    // Wake event flag
  pwc_pkg::pwc_pstate_type   pstate_ff;      // Current power state
  logic                      rx_on_ff;       // Receiver running
  logic [31:0]               rxptr_ff;       // Descriptor pointer
  logic [31:0]               wkreg_ff;       // Wake enables and hits
  logic [31:0]               filt_ff;        // Receive filter control
  logic [31:0]               pic_ff;         // PHY interrupt control
  logic [31:0]               pim_ff;         // PHY interrupt mask
  logic                      cfg_reset_ff;   // Config reset pulse
  logic                      keep_ff;        // Frame accepted
  logic                      store_ff;       // Frame taken into FIFO
  logic [31:0]               rdata_ff;       // Read data
  logic [1:0]                phy_sync_ff;    // PHY irq synchroniser
  logic                      phy_prev_ff;    // For edge detection
  logic [1:0]                pin_sync_ff;    // Pin level synchroniser
  pwc_mp_type                mp_st_ff;       // Wake frame detector
  logic [2:0]                ff_cnt_ff;      // Sync run length
  logic [2:0]                idx_ff;         // Address byte index
  logic [3:0]                copy_ff;        // Address copies seen
  logic                      found_ff;       // Wake frame seen
  pwc_mp_type                nxt_mp_st;
  logic [2:0]                nxt_ff_cnt;
  logic [2:0]                nxt_idx;
  logic [3:0]                nxt_copy;
  logic                      nxt_found;
  logic                      pm_wr;          // Config write to power control
  logic                      wake_op;        // Wake-enabled operation
  logic                      wake_cfgd;      // Any wake source set
  logic                      magic_ev;       // Enabled frame wake
  logic                      phy_ev;         // Enabled PHY wake
  logic                      frame_end;      // Good frame completes
  logic                      filt_ok;        // Normal filter verdict

  assign pm_wr     = reg_req_i.wr && hit(reg_req_i, 1'b1, pwc_pkg::PM_OFS);
  // Sleep when not D0 and enable clear; wake-enabled when not D0 and enable set
  assign wake_op   = wake_en_ff && (pstate_ff != pwc_pkg::PS_D0); // R4 R5
  assign wake_cfgd = |(wkreg_ff & pwc_pkg::WC_EN_MASK);
  assign frame_end = rx_beat_i.valid && rx_beat_i.eof && rx_beat_i.good;
  // Filter enable gates all acceptance
  assign filt_ok   = rx_beat_i.pass && filt_ff[pwc_pkg::RF_ON_BIT]; // R17
  // Only sources enabled in the wake register raise events
  assign magic_ev  = wake_op && frame_end && nxt_found
                     && wkreg_ff[pwc_pkg::WC_MAGIC_BIT]; // R16 R24
  assign phy_ev    = wake_op && phy_sync_ff[1] && !phy_prev_ff
                     && pic_ff[pwc_pkg::PIC_INT_BIT]
                     && wkreg_ff[pwc_pkg::WC_PHY_BIT]; // R16 R24

  // Power management: state field, enable, wake flag
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pstate_ff   <= pwc_pkg::PS_D0;
      wake_en_ff  <= 1'b0;
      wake_sts_ff <= 1'b0;
    end else begin
      if (pm_wr) begin
        // One write may set state and enable together
        pstate_ff  <= pwc_pkg::pwc_pstate_type'(reg_req_i.wdata[1:0]); // R23 R18
        wake_en_ff <= reg_req_i.wdata[pwc_pkg::PM_EN_BIT]; // R1 R22
      end
      // A new event beats a clear in the same cycle
      if (magic_ev || phy_ev) begin
        wake_sts_ff <= 1'b1; // R2
      end else if (pm_wr && reg_req_i.wdata[pwc_pkg::PM_STS_BIT]) begin
        wake_sts_ff <= 1'b0; // R3 R18
      end
    end
  end

  // Leaving D3hot pulses a reset for the rest of config space
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_reset_ff <= 1'b0;
    end else begin
      cfg_reset_ff <= pm_wr && (pstate_ff == pwc_pkg::PS_D3)
                      && (reg_req_i.wdata[1:0] != pwc_pkg::PS_D3); // R11
    end
  end

  // Operational registers; host drives the wake entry order
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_on_ff <= 1'b0;
      rxptr_ff <= pwc_pkg::REG_RST;
      filt_ff  <= pwc_pkg::REG_RST;
      pic_ff   <= pwc_pkg::REG_RST;
      pim_ff   <= pwc_pkg::REG_RST;
    end else if (reg_req_i.wr && !reg_req_i.cfg) begin
      // Disable wins if both command bits are set at once
      if (hit(reg_req_i, 1'b0, pwc_pkg::CMD_OFS)) begin
        if (reg_req_i.wdata[pwc_pkg::CMD_RXOFF_BIT]) begin
          rx_on_ff <= 1'b0; // R12
        end else if (reg_req_i.wdata[pwc_pkg::CMD_RXON_BIT]) begin
          rx_on_ff <= 1'b1; // R13
        end
      end
      if (hit(reg_req_i, 1'b0, pwc_pkg::RXPTR_OFS)) begin
        rxptr_ff <= reg_req_i.wdata;
      end
      if (hit(reg_req_i, 1'b0, pwc_pkg::FILT_OFS)) begin
        filt_ff <= reg_req_i.wdata; // R14
      end
      if (hit(reg_req_i, 1'b0, pwc_pkg::PIC_OFS)) begin
        pic_ff <= reg_req_i.wdata; // R15
      end
      if (hit(reg_req_i, 1'b0, pwc_pkg::PIM_OFS)) begin
        pim_ff <= reg_req_i.wdata;
      end
    end
  end

  // Wake register: enables from software, hit bits set by hardware
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wkreg_ff <= pwc_pkg::REG_RST;
    end else begin
      if (reg_req_i.wr && hit(reg_req_i, 1'b0, pwc_pkg::WAKE_OFS)) begin
        wkreg_ff <= reg_req_i.wdata;
      end
      // Recorded source survives a same-cycle write
      if (magic_ev) begin
        wkreg_ff[pwc_pkg::WC_MAGIC_HIT] <= 1'b1; // R24
      end
      if (phy_ev) begin
        wkreg_ff[pwc_pkg::WC_PHY_HIT] <= 1'b1; // R24
      end
      wkreg_ff[pwc_pkg::WC_PIN_LVL] <= pin_sync_ff[1];
    end
  end

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phy_sync_ff <= 2'b00;
      phy_prev_ff <= 1'b0;
      pin_sync_ff <= 2'b11;
    end else begin
      phy_sync_ff <= {phy_sync_ff[0], phy_irq_i};
      phy_prev_ff <= phy_sync_ff[1];
      pin_sync_ff <= {pin_sync_ff[0], wake_req_pin_i};
    end
  end

  // Wake frame search: sync run then sixteen address copies
  always_comb begin
    nxt_mp_st  = mp_st_ff;
    nxt_ff_cnt = ff_cnt_ff;
    nxt_idx    = idx_ff;
    nxt_copy   = copy_ff;
    nxt_found  = found_ff;
    if (rx_beat_i.valid) begin
      // Start of frame drops any partial match
      if (rx_beat_i.sof) begin
        nxt_mp_st  = MP_SYNC;
        nxt_ff_cnt = 3'h0;
        nxt_found  = 1'b0;
      end
      case (nxt_mp_st)
        MP_SYNC: begin
          if (nxt_ff_cnt == pwc_pkg::SYNC_LEN
              && rx_beat_i.data == mac_byte(station_addr_i, 3'h0)) begin
            nxt_mp_st = MP_ADDR; // R20
            nxt_idx   = 3'h1;
            nxt_copy  = 4'h0;
          end else if (rx_beat_i.data == pwc_pkg::SYNC_BYTE) begin
            // Longer runs still count as a sync run
            if (nxt_ff_cnt != pwc_pkg::SYNC_LEN) begin
              nxt_ff_cnt = nxt_ff_cnt + 3'h1;
            end
          end else begin
            nxt_ff_cnt = 3'h0;
          end
        end
        MP_ADDR: begin
          if (rx_beat_i.data == mac_byte(station_addr_i, nxt_idx)) begin
            if (nxt_idx == pwc_pkg::MAC_LAST) begin
              nxt_idx = 3'h0;
              if (nxt_copy == pwc_pkg::COPY_LAST) begin
                nxt_found  = 1'b1; // R20
                nxt_mp_st  = MP_SYNC;
                nxt_ff_cnt = 3'h0;
              end else begin
                nxt_copy = nxt_copy + 4'h1;
              end
            end else begin
              nxt_idx = nxt_idx + 3'h1;
            end
          end else begin
            // A broken copy may itself open a new sync run
            nxt_mp_st  = MP_SYNC;
            nxt_ff_cnt = (rx_beat_i.data == pwc_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
          end
        end
        default: begin
          nxt_mp_st = MP_SYNC;
        end
      endcase
    end
  end

  // Detector state
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mp_st_ff  <= MP_SYNC;
      ff_cnt_ff <= 3'h0;
      idx_ff    <= 3'h0;
      copy_ff   <= 4'h0;
      found_ff  <= 1'b0;
    end else begin
      mp_st_ff  <= nxt_mp_st;
      ff_cnt_ff <= nxt_ff_cnt;
      idx_ff    <= nxt_idx;
      copy_ff   <= nxt_copy;
      found_ff  <= nxt_found;
    end
  end

  // Frame verdict; with wake enabled both filters must agree
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      keep_ff  <= 1'b0;
      store_ff <= 1'b0;
    end else begin
      keep_ff <= frame_end && filt_ok
                 && (!wake_en_ff || (nxt_found
                 && wkreg_ff[pwc_pkg::WC_MAGIC_BIT])); // R6
      // Low-power states keep filling the FIFO until it is full
      store_ff <= frame_end && filt_ok && !rx_fifo_full_i
                  && (!wake_en_ff || (nxt_found
                  && wkreg_ff[pwc_pkg::WC_MAGIC_BIT])); // R8
    end
  end

  // Read data, registered; unmapped reads return zero
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_ff <= pwc_pkg::REG_RST;
    end else if (reg_req_i.rd) begin
      rdata_ff <= pwc_pkg::REG_RST;
      if (hit(reg_req_i, 1'b1, pwc_pkg::PM_OFS)) begin
        rdata_ff[1:0]                <= pstate_ff;
        rdata_ff[pwc_pkg::PM_EN_BIT]  <= wake_en_ff;
        rdata_ff[pwc_pkg::PM_STS_BIT] <= wake_sts_ff;
      end
      if (hit(reg_req_i, 1'b0, pwc_pkg::CMD_OFS)) begin
        rdata_ff[pwc_pkg::CMD_RXON_BIT] <= rx_on_ff;
      end
      if (hit(reg_req_i, 1'b0, pwc_pkg::RXPTR_OFS)) rdata_ff <= rxptr_ff;
      if (hit(reg_req_i, 1'b0, pwc_pkg::WAKE_OFS)) rdata_ff <= wkreg_ff;
      if (hit(reg_req_i, 1'b0, pwc_pkg::FILT_OFS)) rdata_ff <= filt_ff;
      if (hit(reg_req_i, 1'b0, pwc_pkg::PIC_OFS)) rdata_ff <= pic_ff;
      if (hit(reg_req_i, 1'b0, pwc_pkg::PIM_OFS)) rdata_ff <= pim_ff;
    end
  end

  // Open-drain request: pulled low while flag and enable both hold
  assign wake_req_pin_o = 1'b0; // R21
  assign wake_req_oe_o  = wake_sts_ff && wake_en_ff; // R2 R22
  // Outside D0 DMA, transmit and interrupts are blocked; state holds while clock stops
  assign dma_allow_o    = (pstate_ff == pwc_pkg::PS_D0) && rx_on_ff
                          && (rxptr_ff != pwc_pkg::REG_RST); // R7 R9
  assign tx_allow_o     = (pstate_ff == pwc_pkg::PS_D0); // R7
  assign irq_allow_o    = (pstate_ff == pwc_pkg::PS_D0); // R7
  assign silent_rx_o    = rx_on_ff && (rxptr_ff == pwc_pkg::REG_RST); // R13
  assign phy_power_on_o = (pstate_ff != pwc_pkg::PS_D3)
                          || (wake_en_ff && wake_cfgd); // R10
  assign cfg_reset_o    = cfg_reset_ff;
  assign frame_keep_o   = keep_ff;
  assign frame_store_o  = store_ff;
  assign reg_rdata_o    = rdata_ff;
  assign power_state_o  = pstate_ff;

  event_sets_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (phy_ev || magic_ev) && wake_en_ff && !pm_wr |=> wake_req_oe_o) // R2
    else $error("wake event did not drive request");
  sleep_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !wake_en_ff |-> !wake_req_oe_o) // R4
    else $error("request driven with enable clear");
  set_wins_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    phy_ev && pm_wr && reg_req_i.wdata[pwc_pkg::PM_STS_BIT] |=> wake_sts_ff) // R3
    else $error("event lost to clear");
  flag_hold_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wake_sts_ff && !(pm_wr && reg_req_i.wdata[pwc_pkg::PM_STS_BIT])
    |=> wake_sts_ff) // R3
    else $error("flag cleared without write");
  no_dma_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    pstate_ff != pwc_pkg::PS_D0 |-> !dma_allow_o && !irq_allow_o) // R7
    else $error("bus activity outside D0");
  phy_off_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    pm_wr && reg_req_i.wdata[1:0] == pwc_pkg::PS_D3
    && !reg_req_i.wdata[pwc_pkg::PM_EN_BIT] |=> !phy_power_on_o) // R10
    else $error("PHY powered in D3 sleep");
  leave_d3_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    pm_wr && pstate_ff == pwc_pkg::PS_D3 && reg_req_i.wdata[1:0] == pwc_pkg::PS_D0
    && !reg_req_i.wdata[pwc_pkg::PM_STS_BIT] && !magic_ev && !phy_ev
    |=> cfg_reset_o && $stable(wake_sts_ff) ##1 !cfg_reset_o) // R11
    else $error("no single reset pulse leaving D3");
  state_code_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    pm_wr |=> power_state_o == $past(reg_req_i.wdata[1:0])) // R23
    else $error("power state not taken from write");
  filter_both_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    frame_keep_o && $past(wake_en_ff) |-> $past(found_ff || nxt_found)) // R6
    else $error("frame kept without wake match");
  release_pin_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    pm_wr && !reg_req_i.wdata[pwc_pkg::PM_EN_BIT] |=> !wake_req_oe_o) // R22
    else $error("pin held after enable cleared");
endmodule

// File: dv/pwc_host_model.sv
/*
  Host model: power-management software that programs the controller
  through its register port, including the wake-mode entry sequence.
  Assumes one-cycle wr/rd pulses and read data one cycle after rd.
*/
`timescale 1ns/1ps
module pwc_host_model (
  input  wire logic                  sys_clk_i,
  input  wire logic [31:0]           rdata_i,
  output pwc_pkg::pwc_req_type       req_o
);
  // Idle until the first access
  initial req_o = '0;

  // One access, held for exactly one edge. It opens one edge after the
  // call, so a release and the next request never share a time step.
  // Released fields show the inverse so a stale address never looks valid.
  task automatic access(input logic w, input logic c, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk_i);
    #1;
    req_o = '{wr: w, rd: !w, cfg: c, addr: a, wdata: d};
    @(posedge sys_clk_i);
    #1;
    req_o = '{wr: 1'b0, rd: 1'b0, cfg: !c, addr: ~a, wdata: ~d};
    q = rdata_i;
  endtask

  // Register write
  task automatic wr(input logic c, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, c, a, d, q);
  endtask

  // Register read, data taken at the edge after the request
  task automatic rd(input logic c, input logic [7:0] a, output logic [31:0] q);
    access(1'b0, c, a, 32'h0000_0000, q);
  endtask

  // Wake-mode entry; enable and state land last, in one write
  task automatic enter_wake(input logic [31:0] wc, input logic [31:0] rf,
                            input logic [31:0] pm);
    wr(1'b0, pwc_pkg::CMD_OFS, 32'h0000_0008);
    wr(1'b0, pwc_pkg::RXPTR_OFS, 32'h0000_0000);
    wr(1'b0, pwc_pkg::CMD_OFS, 32'h0000_0004);
    wr(1'b0, pwc_pkg::FILT_OFS, rf);
    if (wc[pwc_pkg::WC_PHY_BIT]) begin
      wr(1'b0, pwc_pkg::PIC_OFS, 32'h0000_0002);
      wr(1'b0, pwc_pkg::PIM_OFS, 32'h0000_0000);
    end
    wr(1'b0, pwc_pkg::WAKE_OFS, wc);
    wr(1'b1, pwc_pkg::PM_OFS, pm);
  endtask
endmodule

// File: dv/testbench.sv
/*
  Self-checking bench for the power and wake controller.
  Assumes the host model above and a pulled-up open-drain wake pin.
*/
`timescale 1ns/1ps
module testbench;
  logic                  sys_clk_i = 1'b0;  // Core clock, 8 ns
  logic                  reset_n_i = 1'b0;  // Async reset, active low
  logic                  clk_run   = 1'b1;  // Lets the clock be stopped in deep states
  pwc_pkg::pwc_req_type  req;               // Host requests
  pwc_pkg::pwc_beat_type beat      = '0;    // Receive bytes
  logic [47:0]           mac       = '0;    // Own station address
  logic                  fifo_full = 1'b0;  // Receive FIFO full level
  logic                  phy_irq   = 1'b0;  // PHY interrupt level
  logic [31:0]           rdata, q;          // Read data
  logic                  oe, pin_o, keep, store, dma, tx, irq, silent, phy_on, cfg_rst;
  logic [1:0]            pstate;            // Power state seen
  logic                  k, s, g, p, wk;    // Frame outcome and random frame shape
  wire                   pin_lvl = oe ? pin_o : 1'b1; // Pull-up when nobody drives the pin
  int                    fails = 0, tests_run = 0, cycles = 0, pulses = 0;

  // Clock; stopping it mimics the host gating the bus clock
  always #4 sys_clk_i = clk_run ? ~sys_clk_i : 1'b0;

  pwc_host_model host (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .req_o(req));

  pwc_wake_ctrl uut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .rx_beat_i(beat), .station_addr_i(mac), .rx_fifo_full_i(fifo_full),
    .phy_irq_i(phy_irq), .wake_req_pin_i(pin_lvl), .wake_req_pin_o(pin_o),
    .wake_req_oe_o(oe), .frame_keep_o(keep), .frame_store_o(store), .dma_allow_o(dma),
    .tx_allow_o(tx), .irq_allow_o(irq), .silent_rx_o(silent), .phy_power_on_o(phy_on),
    .cfg_reset_o(cfg_rst), .power_state_o(pstate));

  // Cycle ceiling against hangs; also counts config reset pulses
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cfg_rst === 1'b1) pulses <= pulses + 1;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  // Verdict and end of run
  task automatic conclude();
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compare and report
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] v);
    tests_run++;
    if (v !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, v);
    end
  endtask

  // Advance n edges, then settle just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // Read a register and compare it
  task automatic rd_chk(input string n, input logic c, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] v;
    host.rd(c, a, v);
    check(n, e, v);
  endtask

  // Expected acceptance: filter verdict, plus a wake match while wake is enabled
  function automatic logic exp_keep(logic en, logic wake, logic good, logic pass);
    return good & pass & (!en | wake);
  endfunction

  // One frame: random lead bytes, optional wake pattern, verdict on the last byte
  task automatic send_frame(input logic wake, input logic good, input logic pass,
                            output logic ko, output logic so);
    logic [7:0] b[$];
    b.push_back(8'h00);
    repeat (2 + $urandom_range(0, 5)) b.push_back(8'($urandom_range(0, 126)));
    if (wake) begin
      repeat (6) b.push_back(pwc_pkg::SYNC_BYTE);
      repeat (16) for (int i = 0; i < 6; i++) b.push_back(mac[8*i +: 8]);
    end
    b.push_back(8'h5a);
    foreach (b[i]) begin
      beat = '{valid: 1'b1, sof: i == 0, eof: i == b.size() - 1, good: good,
               pass: pass, data: b[i]};
      tick(1);
    end
    ko = keep;
    so = store;
    // Idle beat stands one edge, so the next frame starts in a later step
    beat = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, good: 1'b0, pass: 1'b0, data: 8'ha5};
    tick(1);
  endtask

  // Main sequence
  initial begin
    void'($urandom(88));
    mac = 48'({$urandom, $urandom}) & 48'h7f7f_7f7f_7f7f;
    repeat (2) @(posedge sys_clk_i);
    #1;
    reset_n_i = 1'b1;
    check("phy_on_reset", 1, phy_on);
    rd_chk("pm_reset", 1'b1, pwc_pkg::PM_OFS, 32'h0000_0000);
    rd_chk("unmapped", 1'b0, 8'h10, 32'h0000_0000);
    // Every power state code, and what D0 alone allows
    for (int st = 0; st < 4; st++) begin
      host.wr(1'b1, pwc_pkg::PM_OFS, 32'(st));
      check("pstate", 32'(st), pstate);
      check("tx_allow", st == 0, tx);
    end
    host.wr(1'b1, pwc_pkg::PM_OFS, 32'h0000_0000);
    // Random frames in D1 without wake: kept into FIFO, no DMA
    host.wr(1'b0, pwc_pkg::FILT_OFS, 32'hf000_0000);
    host.wr(1'b0, pwc_pkg::RXPTR_OFS, 32'h0000_1000);
    host.wr(1'b0, pwc_pkg::CMD_OFS, 32'h0000_0004);
    check("dma_d0", 1, dma);
    host.wr(1'b1, pwc_pkg::PM_OFS, 32'h0000_0001);
    check("dma_d1", 0, dma);
    repeat (12) begin
      {g, p, wk, fifo_full} = 4'($urandom);
      send_frame(wk, g, p, k, s);
      check("keep_d1", exp_keep(1'b0, wk, g, p), k);
      check("store_d1", exp_keep(1'b0, wk, g, p) & !fifo_full, s);
    end
    fifo_full = 1'b0;
    // Both receive command bits in one write: the disable wins
    host.wr(1'b0, pwc_pkg::CMD_OFS, 32'h0000_000c);
    rd_chk("cmd_rx_off", 1'b0, pwc_pkg::CMD_OFS, 32'h0000_0000);
    // Sleep in D3: PHY off, no wake even for a wake frame
    host.wr(1'b0, pwc_pkg::WAKE_OFS, 32'h0000_0200);
    host.wr(1'b1, pwc_pkg::PM_OFS, 32'h0000_0003);
    check("phy_sleep", 0, phy_on);
    send_frame(1'b1, 1'b1, 1'b1, k, s);
    tick(4);
    check("oe_sleep", 0, oe);
    rd_chk("pm_sleep", 1'b1, pwc_pkg::PM_OFS, 32'h0000_0003);
    clk_run = 1'b0;
    #200;
    clk_run = 1'b1;
    tick(1);
    check("pstate_clkstop", 3, pstate);
    // Frame wake in D3
    host.enter_wake(32'h0000_0200, 32'hf000_0000, 32'h0000_8103);
    check("phy_wake", 1, phy_on);
    check("silent", 1, silent);
    send_frame(1'b0, 1'b1, 1'b1, k, s);
    check("keep_nonwake", 0, k);
    send_frame(1'b1, 1'b1, 1'b1, k, s);
    check("keep_wake", 1, k);
    tick(3);
    check("oe_wake", 1, oe);
    check("pin_low", 0, pin_o);
    rd_chk("pm_flag", 1'b1, pwc_pkg::PM_OFS, 32'h0000_8103);
    rd_chk("wake_frame_src", 1'b0, pwc_pkg::WAKE_OFS, 32'h0200_0200);
    host.wr(1'b1, pwc_pkg::PM_OFS, 32'h0000_0103);
    rd_chk("flag_kept", 1'b1, pwc_pkg::PM_OFS, 32'h0000_8103);
    pulses = 0;
    host.wr(1'b1, pwc_pkg::PM_OFS, 32'h0000_0100);
    tick(3);
    check("cfg_pulse", 1, pulses);
    rd_chk("pm_exit", 1'b1, pwc_pkg::PM_OFS, 32'h0000_8100);
    check("oe_held", 1, oe);
    host.wr(1'b1, pwc_pkg::PM_OFS, 32'h0000_8000);
    check("oe_released", 0, oe);
    // PHY wake in D1; the synced edge meets a flag clear in one cycle
    host.enter_wake(32'h0000_0001, 32'h8000_0000, 32'h0000_8101);
    check("pstate_d1", 1, pstate);
    check("irq_d1", 0, irq);
    phy_irq = 1'b1;
    tick(1);
    host.wr(1'b1, pwc_pkg::PM_OFS, 32'h0000_8101);
    check("oe_phy", 1, oe);
    tick(3);
    rd_chk("wake_phy_src", 1'b0, pwc_pkg::WAKE_OFS, 32'h0040_0001);
    phy_irq = 1'b0;
    host.wr(1'b1, pwc_pkg::PM_OFS, 32'h0000_8000);
    check("oe_phy_clr", 0, oe);
    conclude();
  end
endmodule
